// [hw/mbrtu_meter.v]
`timescale 1ns/1ps
`include "mbrtu_defs.vh"
module mbrtu_meter
#(
  parameter BIT_CYC = `MBRTU_BIT_CYC
)
(
  input wire CLK,
  input wire ARST_N,
  input wire RXD,
  input wire [7:0] SERIAL_LAST2,
  input wire [31:0] PRESSURE_VAL,
  input wire [31:0] FLOW_VAL,
  input wire [31:0] VOLUME_VAL,
  output reg TXD,
  output reg TX_EN
);
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_SEND = 4'b0100;
  localparam S_CRC = 4'b1000;
  // All serial timing but the response delay scales from the bit time, so a shorter bit shortens the gap too
  localparam integer HALF_CYC = BIT_CYC / 2;
  localparam integer GAP_CYC = BIT_CYC * `MBRTU_CHAR_BITS * `MBRTU_GAP_CHARS;

  reg rst_a_ff, rst_b_ff;
  wire rst_n = rst_b_ff;
  reg rx_a_ff, rx_b_ff;
  reg [7:0] addr_ff;
  reg addr_ok_ff;
  reg [19:0] gap_ff;
  reg [12:0] rbit_ff;
  reg [3:0] rcnt_ff;
  reg rbusy_ff;
  reg [7:0] rsh_ff;
  reg [7:0] frame_ff [0:7];
  reg [3:0] flen_ff;
  reg ovf_ff;
  reg [15:0] rcrc_ff;
  reg [3:0] st_ff;
  reg [19:0] dly_ff;
  reg [7:0] tx_len_ff;
  reg [7:0] tx_idx_ff;
  reg [15:0] tcrc_ff;
  reg [9:0] tsh_ff;
  reg [3:0] tbit_ff;
  reg [12:0] tcyc_ff;
  reg tbusy_ff;
  reg [1:0] crc_idx_ff;
  reg exc_ff;
  reg [7:0] exc_code_ff;
  reg [15:0] start_ff;
  reg [7:0] tx_byte;

  // CRC-16 update of one byte, reflected polynomial
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        x = x[0] ? ((x >> 1) ^ `MBRTU_CRC_POLY) : (x >> 1);
      crc_byte = x;
    end
  endfunction

  // Register address of the word being sent: odd index is its high byte, even its low
  wire [15:0] word_addr = start_ff + {9'h000, tx_idx_ff[7:1]} -
    {15'h0000, ~tx_idx_ff[0]} - 16'h0001;
  reg [15:0] word_val;

  // Word of the channel map at that address, zero in gaps; a process, not a function,
  // so that a change of a live value is seen at once
  always @*
  begin
    case (word_addr)
      `MBRTU_REG_PRESSURE: word_val = PRESSURE_VAL[15:0]; // low word first
      `MBRTU_REG_PRESSURE + 16'h0001: word_val = PRESSURE_VAL[31:16];
      `MBRTU_REG_FLOW: word_val = FLOW_VAL[15:0];
      `MBRTU_REG_FLOW + 16'h0001: word_val = FLOW_VAL[31:16];
      `MBRTU_REG_VOLUME: word_val = VOLUME_VAL[15:0];
      `MBRTU_REG_VOLUME + 16'h0001: word_val = VOLUME_VAL[31:16];
      default: word_val = 16'h0000;
    endcase
  end

  // Reset release and RX synchroniser
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
      rx_a_ff <= 1'b1;
      rx_b_ff <= 1'b1;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
      rx_a_ff <= RXD;
      rx_b_ff <= rx_a_ff;
    end
  end

  wire [15:0] q_addr = {frame_ff[2], frame_ff[3]};
  wire [15:0] q_qty = {frame_ff[4], frame_ff[5]};
  wire [16:0] q_end = {1'b0, q_addr} + {1'b0, q_qty};
  wire gap_hit = (gap_ff == GAP_CYC);

  // Outgoing byte: header, data words high byte first, or exception code
  always @*
  begin
    tx_byte = 8'h00;
    if (tx_idx_ff == 8'h00)
      tx_byte = addr_ff;
    else if (tx_idx_ff == 8'h01)
      // An exception echoes the requested function with its top bit set
      tx_byte = exc_ff ? (frame_ff[1] | `MBRTU_EXC_FLAG) : `MBRTU_FC_READ_HOLD;
    else if (tx_idx_ff == 8'h02)
      tx_byte = exc_ff ? exc_code_ff : (tx_len_ff - 8'h03);
    else if (tx_idx_ff[0])
      tx_byte = word_val[15:8];
    else
      tx_byte = word_val[7:0];
  end

  // Receiver, frame assembly and reply sequencer
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_ff <= 8'h00; addr_ok_ff <= 1'b0; gap_ff <= 20'h00000;
      rbit_ff <= 13'h0000; rcnt_ff <= 4'h0; rbusy_ff <= 1'b0; rsh_ff <= 8'h00;
      flen_ff <= 4'h0; ovf_ff <= 1'b0; rcrc_ff <= `MBRTU_CRC_INIT; st_ff <= S_IDLE;
      dly_ff <= 20'h00000; tx_len_ff <= 8'h00; tx_idx_ff <= 8'h00;
      tcrc_ff <= `MBRTU_CRC_INIT; tsh_ff <= 10'h3FF; tbit_ff <= 4'h0;
      tcyc_ff <= 13'h0000; tbusy_ff <= 1'b0; crc_idx_ff <= 2'b00; exc_ff <= 1'b0;
      exc_code_ff <= 8'h00; start_ff <= 16'h0000; TXD <= 1'b1; TX_EN <= 1'b0;
    end
    else
    begin
      // Address is captured once after reset; a BCD-coded serial digit pair
      if (!addr_ok_ff)
      begin
        addr_ff <= {4'h0, SERIAL_LAST2[7:4]} * 8'h0A + {4'h0, SERIAL_LAST2[3:0]};
        addr_ok_ff <= 1'b1;
      end
      // 8N1 receiver, sampling mid bit
      if (!rbusy_ff)
      begin
        if (!rx_b_ff && st_ff == S_IDLE)
        begin
          rbusy_ff <= 1'b1; rbit_ff <= 13'h0000; rcnt_ff <= 4'h0;
        end
      end
      else if (rbit_ff == (rcnt_ff == 4'h0 ? HALF_CYC - 1 : BIT_CYC - 1))
      begin
        rbit_ff <= 13'h0000;
        rcnt_ff <= rcnt_ff + 4'h1;
        if (rcnt_ff >= 4'h1 && rcnt_ff <= 4'h8)
          rsh_ff <= {rx_b_ff, rsh_ff[7:1]};
        if (rcnt_ff == 4'h9)
        begin
          rbusy_ff <= 1'b0; // Stop bit: store byte, CRC runs on the fly
          rcrc_ff <= crc_byte(rcrc_ff, rsh_ff);
          if (flen_ff < 4'h8)
            frame_ff[flen_ff[2:0]] <= rsh_ff;
          else
            ovf_ff <= 1'b1;
          if (flen_ff != 4'hF)
            flen_ff <= flen_ff + 4'h1;
        end
      end
      else
        rbit_ff <= rbit_ff + 13'h0001;
      // Idle gap counter; restarted by any line activity
      if (rbusy_ff || !rx_b_ff)
        gap_ff <= 20'h00000;
      else if (!gap_hit)
        gap_ff <= gap_ff + 20'h00001;
      case (st_ff)
        S_IDLE:
        begin
          if (gap_hit && flen_ff != 4'h0) // frame ends on 7-char silence
          begin
            flen_ff <= 4'h0; ovf_ff <= 1'b0; rcrc_ff <= `MBRTU_CRC_INIT;
            // Residual CRC of zero means good frame; read requests are 8 bytes
            if (rcrc_ff == 16'h0000 && frame_ff[0] == addr_ff && !ovf_ff)
            begin
              start_ff <= q_addr; st_ff <= S_WAIT; dly_ff <= 20'h00000;
              exc_ff <= 1'b1; tx_len_ff <= 8'h03;
              if (frame_ff[1] != `MBRTU_FC_READ_HOLD || flen_ff != 4'h8)
                exc_code_ff <= `MBRTU_EXC_ILL_FUNC;
              else if (q_qty == 16'h0000 || q_qty > `MBRTU_MAX_QTY ||
                       q_addr < `MBRTU_REG_FIRST || q_end > {1'b0, `MBRTU_REG_LAST} + 17'h1)
                exc_code_ff <= `MBRTU_EXC_ILL_ADDR;
              else
              begin
                exc_ff <= 1'b0;
                tx_len_ff <= 8'h03 + {q_qty[6:0], 1'b0};
              end
            end
          end
        end
        S_WAIT:
        begin
          dly_ff <= dly_ff + 20'h00001;
          if (dly_ff == `MBRTU_RESP_DELAY_CYC) // no added delay
          begin
            st_ff <= S_SEND; tx_idx_ff <= 8'h00; tcrc_ff <= `MBRTU_CRC_INIT;
            TX_EN <= 1'b1; crc_idx_ff <= 2'b00;
          end
        end
        default:
        begin
          // Serialiser: load a byte, shift 10 bits LSB first
          if (!tbusy_ff)
          begin
            if (st_ff == S_SEND)
            begin
              tsh_ff <= {1'b1, tx_byte, 1'b0};
              tcrc_ff <= crc_byte(tcrc_ff, tx_byte);
              tbusy_ff <= 1'b1; tbit_ff <= 4'h0; tcyc_ff <= 13'h0000;
              tx_idx_ff <= tx_idx_ff + 8'h01;
              if (tx_idx_ff + 8'h01 == tx_len_ff)
                st_ff <= S_CRC;
            end
            else if (crc_idx_ff != 2'b10)
            begin
              // CRC low byte first, then high byte
              tsh_ff <= {1'b1, (crc_idx_ff[0] ? tcrc_ff[15:8] : tcrc_ff[7:0]), 1'b0};
              tbusy_ff <= 1'b1; tbit_ff <= 4'h0; tcyc_ff <= 13'h0000;
              crc_idx_ff <= crc_idx_ff + 2'b01;
            end
            else
            begin
              TX_EN <= 1'b0; st_ff <= S_IDLE;
            end
          end
          else if (tbit_ff == `MBRTU_CHAR_BITS - 1 && tcyc_ff == BIT_CYC - 2)
          begin
            // Stop bit ends a cycle early: the reload cycle shows idle high, which keeps
            // every character on the bit grid with exactly one stop bit
            tcyc_ff <= 13'h0000;
            tbusy_ff <= 1'b0;
          end
          else if (tcyc_ff == BIT_CYC - 1)
          begin
            tcyc_ff <= 13'h0000;
            tsh_ff <= {1'b1, tsh_ff[9:1]};
            tbit_ff <= tbit_ff + 4'h1;
          end
          else
            tcyc_ff <= tcyc_ff + 13'h0001;
          TXD <= tbusy_ff ? tsh_ff[0] : 1'b1;
        end
      endcase
    end
  end
endmodule // mbrtu_meter

// [pkg/mbrtu_defs.vh]
`ifndef MBRTU_DEFS_VH
`define MBRTU_DEFS_VH
// Clock and serial timing
`define MBRTU_CLK_HZ 100000000
`define MBRTU_BAUD 19200
`define MBRTU_BIT_CYC ((`MBRTU_CLK_HZ + `MBRTU_BAUD / 2) / `MBRTU_BAUD)
`define MBRTU_HALF_CYC (`MBRTU_BIT_CYC / 2)
`define MBRTU_CHAR_BITS 10
`define MBRTU_GAP_CHARS 7
`define MBRTU_GAP_CYC (`MBRTU_BIT_CYC * `MBRTU_CHAR_BITS * `MBRTU_GAP_CHARS)
`define MBRTU_RESP_DELAY_MS 0
`define MBRTU_RESP_DELAY_CYC ((`MBRTU_RESP_DELAY_MS * (`MBRTU_CLK_HZ / 1000)) + 1)
// Protocol codes
`define MBRTU_FC_READ_HOLD 8'h03
`define MBRTU_EXC_FLAG 8'h80
`define MBRTU_EXC_ILL_FUNC 8'h01
`define MBRTU_EXC_ILL_ADDR 8'h02
`define MBRTU_CRC_INIT 16'hFFFF
`define MBRTU_CRC_POLY 16'hA001
// Channel map, register addresses (16-bit words)
`define MBRTU_REG_PRESSURE 16'h0002
`define MBRTU_REG_FLOW 16'h0006
`define MBRTU_REG_VOLUME 16'h0008
`define MBRTU_REG_FIRST 16'h0002
`define MBRTU_REG_LAST 16'h0009
`define MBRTU_MAX_QTY 16'h007D
`endif

// [verif/mbrtu_master_model.sv]
`timescale 1ns/1ps
`include "mbrtu_defs.vh"
module mbrtu_master_model
#(
  parameter integer BIT = `MBRTU_BIT_CYC
)
(
  input wire clk,
  input wire rx,
  output reg tx
);
  // Bus idles high through the line bias
  initial tx = 1'b1;
  // Reflected CRC-16 step for one byte
  function [15:0] crc_add(input [15:0] c, input [7:0] d);
    integer i;
    begin
      crc_add = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        crc_add = (crc_add >> 1) ^ (crc_add[0] ? `MBRTU_CRC_POLY : 16'h0000);
    end
  endfunction
  // One 8N1 character, LSB first
  task send_byte(input [7:0] b);
    integer i;
    reg [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1)
      begin
        tx <= #1 f[i];
        repeat (BIT) @(posedge clk);
      end
    end
  endtask
  // Request of six bytes, CRC low byte first; bad spoils the CRC on purpose
  task send_req(input [47:0] p, input bad);
    integer i;
    reg [15:0] c;
    begin
      c = `MBRTU_CRC_INIT;
      for (i = 5; i >= 0; i = i - 1)
      begin
        send_byte(p[i * 8 +: 8]);
        c = crc_add(c, p[i * 8 +: 8]);
      end
      if (bad)
        c = ~c;
      send_byte(c[7:0]);
      send_byte(c[15:8]);
    end
  endtask
  // Mid-bit sampling on the falling clock edge, clear of the edge that moves the line;
  // the wait is shorter than the reply timeout to keep runs short
  task recv_byte(input integer lim, output [7:0] b, output got);
    integer n;
    begin
      n = 0;
      b = 8'h00;
      while (rx !== 1'b0 && n < lim)
      begin
        @(negedge clk);
        n = n + 1;
      end
      got = (rx === 1'b0);
      if (got)
      begin
        repeat (BIT / 2) @(negedge clk);
        repeat (8)
        begin
          repeat (BIT) @(negedge clk);
          b = {rx, b[7:1]};
        end
        repeat (BIT) @(negedge clk);
      end
    end
  endtask
endmodule // mbrtu_master_model

// [verif/mbrtu_meter_properties.sv]
`timescale 1ns/1ps
`include "mbrtu_defs.vh"
module mbrtu_meter_props
#(
  parameter int BIT = `MBRTU_BIT_CYC
)
(
  input wire CLK,
  input wire ARST_N,
  input wire RXD,
  input wire [7:0] SERIAL_LAST2,
  input wire [31:0] PRESSURE_VAL,
  input wire [31:0] FLOW_VAL,
  input wire [31:0] VOLUME_VAL,
  input wire TXD,
  input wire TX_EN
);
  localparam int GAP = BIT * `MBRTU_CHAR_BITS * `MBRTU_GAP_CHARS;
  reg [31:0] run_ff;
  reg [31:0] idle_ff;
  reg last_ff;
  reg ok_ff;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Level run lengths; the first edge of a reply is skipped, it follows idle
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      run_ff <= 32'h00000000;
      idle_ff <= 32'h00000000;
      last_ff <= 1'b1;
      ok_ff <= 1'b0;
    end
    else
    begin
      last_ff <= TXD;
      run_ff <= (TXD != last_ff) ? 32'h00000001 : run_ff + 32'h00000001;
      idle_ff <= RXD ? idle_ff + 32'h00000001 : 32'h00000000;
      ok_ff <= TX_EN && (ok_ff || TXD != last_ff);
    end
  end
  a_reset_idle: assert property ($rose(ARST_N) |-> (TXD && !TX_EN) [*4])
    else $error("line busy after reset");
  a_idle_high: assert property (!TX_EN |-> TXD)
    else $error("line low while not driven");
  a_start_soon: assert property ($rose(TX_EN) |-> ##[0:3] !TXD)
    else $error("no start bit after enable");
  a_bit_time: assert property (ok_ff && TXD != last_ff |-> run_ff % BIT == 0)
    else $error("bit edge off the baud grid");
  a_low_short: assert property (TXD && !last_ff && ok_ff |-> run_ff <= 9 * BIT)
    else $error("low run longer than a character");
  a_stop_full: assert property ($fell(TX_EN) |-> TXD && run_ff >= BIT - 4)
    else $error("enable dropped inside last character");
  a_reply_gap: assert property ($rose(TX_EN) |-> idle_ff >= GAP && idle_ff <= GAP + 10 * BIT)
    else $error("reply not right after idle gap");
  a_en_hold: assert property ($rose(TX_EN) |=> TX_EN [*8])
    else $error("enable pulse too short");
  c_reply: cover property ($rose(TX_EN));
  c_end: cover property ($fell(TX_EN));
  c_gap: cover property (idle_ff == GAP);
endmodule // mbrtu_meter_props

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "mbrtu_defs.vh"
module tb_top;
  // Short bit time keeps the run brief; all bench timing but the reset pulses and the 100000-cycle watchdog scales from it
  localparam integer TB_BIT = 32;
  localparam integer GAP = TB_BIT * `MBRTU_CHAR_BITS * `MBRTU_GAP_CHARS;
  localparam [7:0] ADDR = 8'h2F;
  localparam [31:0] PV = 32'h40490FDB;
  localparam [31:0] FV = 32'h42C81234;
  localparam [31:0] VV = 32'h0001E240;
  reg clk;
  reg arst_n;
  wire rxd;
  wire txd;
  wire tx_en;
  reg [7:0] exp [0:20];
  reg [7:0] rx [0:20];
  reg [7:0] b;
  reg [7:0] serial;
  reg got;
  integer i;
  integer tn;
  integer bad_count;
  integer num_checks;
  mbrtu_master_model #(.BIT(TB_BIT)) m (.clk(clk), .rx(txd), .tx(rxd));
  mbrtu_meter #(.BIT_CYC(TB_BIT)) dut (.CLK(clk), .ARST_N(arst_n), .RXD(rxd),
    .SERIAL_LAST2(serial),
    .PRESSURE_VAL(PV), .FLOW_VAL(FV), .VOLUME_VAL(VV), .TXD(txd), .TX_EN(tx_en));
  task check(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Word order low word first, each word high byte first
  task put32(input integer k, input [31:0] v);
    begin
      exp[k] = v[15:8];
      exp[k + 1] = v[7:0];
      exp[k + 2] = v[31:24];
      exp[k + 3] = v[23:16];
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Next request only after the reply and a full idle gap
  task pause;
    begin
      repeat (GAP + TB_BIT) @(posedge clk);
      tn = tn + 1;
      $display("test %0d done", tn);
    end
  endtask
  task get_reply(input integer n);
    reg [15:0] c;
    begin
      c = `MBRTU_CRC_INIT;
      for (i = 0; i < n; i = i + 1)
        c = m.crc_add(c, exp[i]);
      exp[n] = c[7:0];
      exp[n + 1] = c[15:8];
      for (i = 0; i < n + 2; i = i + 1)
      begin
        m.recv_byte(2 * GAP, b, got);
        rx[i] = b;
        check("reply byte", {23'h0, 1'b1, exp[i]}, {23'h0, got, b});
      end
      pause;
    end
  endtask
  task no_reply;
    begin
      m.recv_byte(2 * GAP, b, got);
      check("silence", 32'h0, {31'h0, got});
      pause;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    // About 2300 bit times of traffic fit inside this span with margin
    repeat (100000) @(posedge clk);
    bad_count = bad_count + 1;
    finish_test;
  end
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    tn = 0;
    serial = 8'h47;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (GAP) @(posedge clk);
    m.send_req({ADDR, 8'h03, 32'h00020008}, 1'b0);
    exp[0] = ADDR;
    exp[1] = 8'h03;
    exp[2] = 8'h10;
    put32(3, PV);
    put32(7, 32'h0);
    put32(11, FV);
    put32(15, VV);
    get_reply(19);
    check("msb float", PV, {rx[5], rx[6], rx[3], rx[4]});
    check("lsb float", {PV[7:0], PV[15:8], PV[23:16], PV[31:24]}, {rx[4], rx[3], rx[6], rx[5]});
    m.send_req({ADDR ^ 8'h01, 8'h03, 32'h00020008}, 1'b0);
    no_reply;
    m.send_req({ADDR, 8'h03, 32'h00020008}, 1'b1);
    no_reply;
    exp[1] = 8'h84;
    exp[2] = 8'h01;
    m.send_req({ADDR, 8'h04, 32'h00020002}, 1'b0);
    get_reply(3);
    exp[1] = 8'h83;
    exp[2] = 8'h02;
    m.send_req({ADDR, 8'h03, 32'h00000002}, 1'b0);
    get_reply(3);
    // Reset again in mid-run with other serial digits: the address must follow them
    #1 arst_n = 1'b0;
    serial = 8'h15;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (GAP) @(posedge clk);
    m.send_req({ADDR, 8'h03, 32'h00080002}, 1'b0);
    no_reply;
    m.send_req({8'h0F, 8'h03, 32'h00080002}, 1'b0);
    exp[0] = 8'h0F;
    exp[1] = 8'h03;
    exp[2] = 8'h04;
    put32(3, VV);
    get_reply(7);
    finish_test;
  end
endmodule // tb_top
bind mbrtu_meter mbrtu_meter_props #(.BIT(BIT_CYC)) u_props (.CLK(CLK), .ARST_N(ARST_N),
  .RXD(RXD),
  .SERIAL_LAST2(SERIAL_LAST2), .PRESSURE_VAL(PRESSURE_VAL), .FLOW_VAL(FLOW_VAL),
  .VOLUME_VAL(VOLUME_VAL), .TXD(TXD), .TX_EN(TX_EN));
